// ---- design/tpsc_regs.svh ----
// Purpose: register map, field positions and reset values of the
//          timestamp, synthesizer and serial lane configuration bank
// Assumes: 15-bit register addresses, 8-bit registers
// Notes:   definitions only
`ifndef TPSC_REGS_SVH
`define TPSC_REGS_SVH

// register addresses
`define TPSC_ADDR_TS_CTRL     15'h003b
`define TPSC_ADDR_REFO_CTRL   15'h003c
`define TPSC_ADDR_DIV_PV      15'h003d
`define TPSC_ADDR_DIV_N       15'h003e
`define TPSC_ADDR_OSC_BIAS    15'h003f
`define TPSC_ADDR_PREEMPH     15'h0048

// reset values of the implemented fields
`define TPSC_RST_TS_CTRL      2'h0
`define TPSC_RST_REFO_EN      1'h1
`define TPSC_RST_DIV_P        2'h0
`define TPSC_RST_DIV_V        2'h0
`define TPSC_RST_DIV_N        6'h20
`define TPSC_RST_OSC_BIAS     7'h4f
`define TPSC_RST_PREEMPH      4'h0

// field positions
`define TPSC_BIT_TS_RECV      0
`define TPSC_BIT_TS_PECL      1
`define TPSC_BIT_REFO_EN      0
`define TPSC_FLD_DIV_P        3:2
`define TPSC_FLD_DIV_V        1:0
`define TPSC_FLD_DIV_N        5:0
`define TPSC_FLD_OSC_BIAS     6:0
`define TPSC_FLD_PREEMPH      3:0

// serial frame layout: 1 direction bit, 15 address bits, 8 data bits
`define TPSC_FRAME_LAST       5'h17
`define TPSC_HDR_LAST         5'h0f
`define TPSC_HDR_BITS         5'h10
`define TPSC_LANES            8

// divider ratios per code
`define TPSC_P_RATIO_C0       3'h1
`define TPSC_P_RATIO_C1       3'h2
`define TPSC_P_RATIO_C2       3'h4
`define TPSC_V_RATIO_C0       3'h5
`define TPSC_V_RATIO_C1       3'h4
`define TPSC_V_RATIO_C2       3'h3
`define TPSC_RATIO_RSVD       3'h0

`endif

// ---- design/tpsc_pkg.sv ----
// Purpose: shared types of the configuration bank
// Assumes: nothing
// Notes:   state of the serial port receiver
package tpsc_pkg;
  typedef enum logic [0:0] {
    PORT_IDLE,
    PORT_SHIFT
  } tpsc_port_state_t;
endpackage

// ---- design/tpsc_sync2.sv ----
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to sys_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module tpsc_sync2 #(
  parameter int          WIDTH   = 4,
  parameter logic [3:0]  RST_VAL = 4'h0
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1_reg <= RST_VAL[WIDTH-1:0];
      syncOut    <= RST_VAL[WIDTH-1:0];
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

// ---- design/tpsc_config_bank.sv ----
// Purpose: configuration bank for timestamp input, reference output,
//          synthesizer dividers, oscillator bias and lane pre-emphasis
// Assumes: serial port clock at most sys_clk / 8; frames of 24 bits,
//          msb first, sampled on the rising port clock edge
// Notes:   reserved bits are not stored and read back as zero
`timescale 1ns/1ps
`default_nettype none
`include "tpsc_regs.svh"

module tpsc_config_bank
  import tpsc_pkg::*;
(
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // serial programming port pins
  input  wire logic                          spiCsN,
  input  wire logic                          spiSclk,
  input  wire logic                          spiSdi,
  output logic                               spiSdo,
  // synthesizer enable pin and override
  input  wire logic                          pllEnPin,
  input  wire logic                          synthOverrideEnable,
  input  wire logic                          synth_enable_override_value,
  // timestamp input controls
  output logic                               timestamp_input_enable,
  output logic                               timestamp_pecl_termination_enable,
  // reference output and synthesizer
  output logic                               synthEnable,
  output logic                               pll_ref_output_enable,
  output logic                               pllRefOutputDrive,
  output logic [2:0]                         synthDivPRatio,
  output logic [2:0]                         synthDivVRatio,
  output logic [5:0]                         synthDivNRatio,
  output logic [6:0]                         oscillator_bias_level,
  // serial lanes
  output logic [`TPSC_LANES*4-1:0]           lane_preemphasis_level
);

  logic [3:0]       pinSync;
  logic             csNS;
  logic             sclkS;
  logic             sdiS;
  logic             pllEnS;
  logic             sclkD_reg;
  logic             sclkRise;
  logic             sclkFall;
  tpsc_port_state_t state_reg;
  logic [4:0]       bitCnt_reg;
  logic [15:0]      hdr_reg;
  logic [7:0]       rdShift_reg;
  logic             wrEn;
  logic [14:0]      wrAddr;
  logic [7:0]       wrData;
  logic [1:0]       tsCtrl_reg;
  logic             refoEn_reg;
  logic [1:0]       divP_reg;
  logic [1:0]       divV_reg;
  logic [5:0]       divN_reg;
  logic [6:0]       oscBias_reg;
  logic [3:0]       preEmph_reg;

  function automatic logic [2:0] pRatio(input logic [1:0] code);
    if (code == 2'h0)      pRatio = `TPSC_P_RATIO_C0;
    else if (code == 2'h1) pRatio = `TPSC_P_RATIO_C1;
    else if (code == 2'h2) pRatio = `TPSC_P_RATIO_C2;
    else                   pRatio = `TPSC_RATIO_RSVD;
  endfunction

  function automatic logic [2:0] vRatio(input logic [1:0] code);
    if (code == 2'h0)      vRatio = `TPSC_V_RATIO_C0;
    else if (code == 2'h1) vRatio = `TPSC_V_RATIO_C1;
    else if (code == 2'h2) vRatio = `TPSC_V_RATIO_C2;
    else                   vRatio = `TPSC_RATIO_RSVD;
  endfunction

  // read mux: reserved bits return zero
  function automatic logic [7:0] readReg(input logic [14:0] addr);
    if (addr == `TPSC_ADDR_TS_CTRL)        readReg = {6'h00, tsCtrl_reg};
    else if (addr == `TPSC_ADDR_REFO_CTRL) readReg = {7'h00, refoEn_reg};
    else if (addr == `TPSC_ADDR_DIV_PV)
      readReg = {4'h0, divP_reg, divV_reg};
    else if (addr == `TPSC_ADDR_DIV_N)     readReg = {2'h0, divN_reg};
    else if (addr == `TPSC_ADDR_OSC_BIAS)  readReg = {1'h0, oscBias_reg};
    else if (addr == `TPSC_ADDR_PREEMPH)   readReg = {4'h0, preEmph_reg};
    else                                   readReg = 8'h00;
  endfunction

  tpsc_sync2 #(.WIDTH(4), .RST_VAL(4'h1)) pinSyncInst (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn ({pllEnPin, spiSdi, spiSclk, spiCsN}),
    .syncOut (pinSync)
  );

  assign csNS     = pinSync[0];
  assign sclkS    = pinSync[1];
  assign sdiS     = pinSync[2];
  assign pllEnS   = pinSync[3];
  assign sclkRise = sclkS & ~sclkD_reg & ~csNS;
  assign sclkFall = ~sclkS & sclkD_reg & ~csNS;

  always_ff @(posedge sys_clk) begin
    if (rst) sclkD_reg <= 1'h0;
    else     sclkD_reg <= sclkS;
  end

  // frame receiver
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg  <= PORT_IDLE;
      bitCnt_reg <= 5'h00;
      hdr_reg    <= 16'h0000;
    end else begin
      case (state_reg)
        PORT_IDLE: begin
          bitCnt_reg <= 5'h00;
          if (!csNS) state_reg <= PORT_SHIFT;
        end
        PORT_SHIFT: begin
          if (csNS) begin
            state_reg <= PORT_IDLE;
          end else if (sclkRise) begin
            if (bitCnt_reg <= `TPSC_HDR_LAST) hdr_reg <= {hdr_reg[14:0], sdiS};
            // count stops after the last bit: extra clocks are ignored
            if (bitCnt_reg <= `TPSC_FRAME_LAST)
              bitCnt_reg <= bitCnt_reg + 5'h01;
          end
        end
        default: state_reg <= PORT_IDLE;
      endcase
    end
  end

  // write data: 7 bits from the shifter plus the final sampled bit
  assign wrAddr = hdr_reg[14:0];
  assign wrData = {rdShift_reg[6:0], sdiS};
  assign wrEn   = (state_reg == PORT_SHIFT) && sclkRise && !hdr_reg[15]
                  && (bitCnt_reg == `TPSC_FRAME_LAST);

  // data phase shifter, read data leave on falling port clock edges
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdShift_reg <= 8'h00;
      spiSdo      <= 1'h0;
    end else if (state_reg != PORT_SHIFT) begin
      spiSdo <= 1'h0;
    end else if (sclkRise && bitCnt_reg == `TPSC_HDR_LAST) begin
      rdShift_reg <= hdr_reg[14] ? readReg({hdr_reg[13:0], sdiS}) : 8'h00;
    end else if (sclkRise && bitCnt_reg >= `TPSC_HDR_BITS
                 && !hdr_reg[15]) begin
      rdShift_reg <= {rdShift_reg[6:0], sdiS};
    end else if (sclkFall && bitCnt_reg >= `TPSC_HDR_BITS
                 && hdr_reg[15]) begin
      spiSdo      <= rdShift_reg[7];
      rdShift_reg <= {rdShift_reg[6:0], 1'h0};
    end
  end

  // register file; only implemented fields are stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tsCtrl_reg  <= `TPSC_RST_TS_CTRL;
      refoEn_reg  <= `TPSC_RST_REFO_EN;
      divP_reg    <= `TPSC_RST_DIV_P;
      divV_reg    <= `TPSC_RST_DIV_V;
      divN_reg    <= `TPSC_RST_DIV_N;
      oscBias_reg <= `TPSC_RST_OSC_BIAS;
      preEmph_reg <= `TPSC_RST_PREEMPH;
    end else if (wrEn) begin
      if (wrAddr == `TPSC_ADDR_TS_CTRL)
        tsCtrl_reg <= {wrData[`TPSC_BIT_TS_PECL], wrData[`TPSC_BIT_TS_RECV]};
      else if (wrAddr == `TPSC_ADDR_REFO_CTRL)
        refoEn_reg <= wrData[`TPSC_BIT_REFO_EN];
      else if (wrAddr == `TPSC_ADDR_DIV_PV) begin
        divP_reg <= wrData[`TPSC_FLD_DIV_P];
        divV_reg <= wrData[`TPSC_FLD_DIV_V];
      end else if (wrAddr == `TPSC_ADDR_DIV_N)
        divN_reg <= wrData[`TPSC_FLD_DIV_N];
      else if (wrAddr == `TPSC_ADDR_OSC_BIAS)
        oscBias_reg <= wrData[`TPSC_FLD_OSC_BIAS];
      else if (wrAddr == `TPSC_ADDR_PREEMPH)
        preEmph_reg <= wrData[`TPSC_FLD_PREEMPH];
    end
  end

  // analog control outputs, registered
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timestamp_input_enable            <= 1'h0;
      timestamp_pecl_termination_enable <= 1'h0;
      synthEnable                       <= 1'h0;
      pll_ref_output_enable             <= 1'h0;
      pllRefOutputDrive                 <= 1'h0;
      synthDivPRatio                    <= `TPSC_P_RATIO_C0;
      synthDivVRatio                    <= `TPSC_V_RATIO_C0;
      synthDivNRatio                    <= `TPSC_RST_DIV_N;
      oscillator_bias_level             <= `TPSC_RST_OSC_BIAS;
      lane_preemphasis_level            <= '0;
    end else begin
      timestamp_input_enable <= tsCtrl_reg[`TPSC_BIT_TS_RECV];
      timestamp_pecl_termination_enable
        <= tsCtrl_reg[`TPSC_BIT_TS_PECL];
      synthEnable <= synthOverrideEnable
        ? synth_enable_override_value : pllEnS;
      pll_ref_output_enable  <= refoEn_reg;
      pllRefOutputDrive      <= refoEn_reg & (synthOverrideEnable
        ? synth_enable_override_value : pllEnS);
      synthDivPRatio         <= pRatio(divP_reg);
      synthDivVRatio         <= vRatio(divV_reg);
      synthDivNRatio         <= divN_reg;
      oscillator_bias_level  <= oscBias_reg;
      lane_preemphasis_level <= {`TPSC_LANES{preEmph_reg}};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_recv_enable: assert property (
    wrEn && wrAddr == `TPSC_ADDR_TS_CTRL |=> ##1
      timestamp_input_enable == $past(wrData[0], 2))
    else $error("timestamp enable does not follow write");
  a_pecl_mode: assert property (
    wrEn && wrAddr == `TPSC_ADDR_TS_CTRL |-> ##2
      timestamp_pecl_termination_enable == $past(wrData[1], 2))
    else $error("pecl mode does not follow write");
  a_refo_drive: assert property (
    pllRefOutputDrive == ($past(refoEn_reg) && synthEnable))
    else $error("reference output driven without enables");
  a_div_p: assert property (
    $past(divP_reg) == 2'h2 |-> synthDivPRatio == 3'h4)
    else $error("second divider ratio wrong");
  a_div_v: assert property (
    $past(divV_reg) == 2'h0 |-> synthDivVRatio == 3'h5)
    else $error("first divider ratio wrong");
  a_div_n: assert property (
    wrEn && wrAddr == `TPSC_ADDR_DIV_N |-> ##2
      synthDivNRatio == $past(wrData[5:0], 2))
    else $error("third divider does not follow write");
  a_lane_common: assert property (
    lane_preemphasis_level == {`TPSC_LANES{lane_preemphasis_level[3:0]}})
    else $error("lanes carry different pre-emphasis");
  a_synth_pin: assert property (
    !synthOverrideEnable [*2] |-> synthEnable == $past(pllEnS))
    else $error("synthesizer enable does not follow pin");

  c_write_frame: cover property (wrEn);
  c_read_frame: cover property (
    state_reg == PORT_SHIFT && hdr_reg[15] && sclkFall);
  c_override: cover property (synthOverrideEnable && synthEnable);
  c_refo_on: cover property (pllRefOutputDrive);

endmodule
`default_nettype wire

// ---- verification/tpsc_host_model.sv ----
// Purpose: host processor that programs the bank over the serial port
// Assumes: one frame at a time; msb first, 24 bits per frame
// Notes:   halfCyc sets the clock phase length, cutAt aborts a frame
`timescale 1ns/1ps
`default_nettype none
module tpsc_host_model (
  // clock
  input  wire logic sys_clk,
  // serial port pins
  output logic      spiCsN,
  output logic      spiSclk,
  output logic      spiSdi,
  input  wire logic spiSdo
);
  int halfCyc = 5;
  int cutAt   = -1;

  initial begin
    spiCsN  = 1'b1;
    spiSclk = 1'b0;
    spiSdi  = 1'b0;
  end

  task automatic xfer(input logic isRead, input logic [14:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    logic [23:0] frame;
    frame = {isRead, addr, wdata};
    rdata = 8'h00;
    @(posedge sys_clk);
    spiCsN <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      if (i == cutAt) break;
      // data line is not driven with meaning during read data bits
      spiSdi <= (isRead && i < 8) ? ~spiSdi : frame[i];
      repeat (halfCyc) @(posedge sys_clk);
      spiSclk <= 1'b1;
      repeat (halfCyc) @(posedge sys_clk);
      if (i < 8) rdata[i] = spiSdo;
      spiSclk <= 1'b0;
    end
    repeat (halfCyc) @(posedge sys_clk);
    spiCsN <= 1'b1;
    spiSdi <= ~spiSdi;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ---- verification/tpsc_config_bank_tb.sv ----
// Purpose: self-checking bench of the configuration bank
// Assumes: host model drives the serial port
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none
`include "tpsc_regs.svh"
module tpsc_config_bank_tb;
  logic        sys_clk, rst, spiCsN, spiSclk, spiSdi, spiSdo;
  logic        pllEnPin, synthOverrideEnable, synth_enable_override_value;
  logic        tsEn, tsPecl, synthEn, refoEn, refoDrive;
  logic [2:0]  divP, divV;
  logic [5:0]  divN;
  logic [6:0]  bias;
  logic [31:0] lanes;
  logic [7:0]  rd;
  int          error_cnt = 0;
  int          n_tests   = 0;

  tpsc_config_bank u_dut (.sys_clk(sys_clk), .rst(rst), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo),
    .pllEnPin(pllEnPin), .synthOverrideEnable(synthOverrideEnable),
    .synth_enable_override_value(synth_enable_override_value),
    .timestamp_input_enable(tsEn),
    .timestamp_pecl_termination_enable(tsPecl), .synthEnable(synthEn),
    .pll_ref_output_enable(refoEn), .pllRefOutputDrive(refoDrive),
    .synthDivPRatio(divP), .synthDivVRatio(divV), .synthDivNRatio(divN),
    .oscillator_bias_level(bias), .lane_preemphasis_level(lanes));
  tpsc_host_model u_host (.sys_clk(sys_clk), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, rd);
  endtask
  task automatic rdreg(input logic [14:0] a, input logic [7:0] e,
                       input string w);
    u_host.xfer(1'b1, a, 8'h00, rd);
    check(32'(rd), 32'(e), w);
  endtask

  task automatic t_reset();
    check(32'(refoEn), 32'h1, "ref enable reset");
    check(32'({divP, divV}), 32'h0d, "pv ratio reset");
    check(32'(divN), 32'h20, "n reset");
    check(32'({tsEn, tsPecl, bias}), 32'h4f, "ts and bias reset");
    rdreg(`TPSC_ADDR_REFO_CTRL, 8'h01, "ref reg reset");
    rdreg(`TPSC_ADDR_DIV_N, 8'h20, "n reg reset");
    rdreg(`TPSC_ADDR_OSC_BIAS, 8'h4f, "bias reg reset");
  endtask

  task automatic t_timestamp();
    for (int c = 0; c < 4; c++) begin
      wr(`TPSC_ADDR_TS_CTRL, 8'(c));
      check(32'(tsEn), 32'(c & 1), "ts enable");
      check(32'(tsPecl), 32'(c >> 1), "ts pecl");
      rdreg(`TPSC_ADDR_TS_CTRL, 8'(c), "ts readback");
    end
  endtask

  task automatic t_dividers();
    logic [17:0] nv;
    nv = {6'h20, 6'h3f, 6'h01};
    pllEnPin <= 1'b0; // synthesizer off while dividers change
    repeat (5) @(posedge sys_clk);
    for (int p = 0; p < 3; p++)
      for (int v = 0; v < 3; v++) begin // code 3 never written
        wr(`TPSC_ADDR_DIV_PV, 8'((p << 2) | v));
        check(32'(divP), 32'(1 << p), "p ratio");
        check(32'(divV), 32'(5 - v), "v ratio");
      end
    rdreg(`TPSC_ADDR_DIV_PV, 8'h0a, "pv readback");
    for (int i = 0; i < 3; i++) begin
      wr(`TPSC_ADDR_DIV_N, {2'h0, nv[6*i +: 6]});
      check(32'(divN), 32'(nv[6*i +: 6]), "n ratio");
    end
    wr(`TPSC_ADDR_OSC_BIAS, 8'h4a);
    check(32'(bias), 32'h4a, "bias level");
    rdreg(`TPSC_ADDR_OSC_BIAS, 8'h4a, "bias readback");
  endtask

  task automatic t_preemph();
    u_host.halfCyc = 12; // slow host
    wr(`TPSC_ADDR_PREEMPH, 8'h0f);
    check(lanes, {8{4'hf}}, "lanes max");
    u_host.halfCyc = 4;
    wr(`TPSC_ADDR_PREEMPH, 8'h05);
    check(lanes, {8{4'h5}}, "lanes mid");
  endtask

  task automatic t_refout();
    logic s;
    for (int e = 0; e < 2; e++) begin
      wr(`TPSC_ADDR_REFO_CTRL, 8'(e));
      check(32'(refoEn), 32'(e), "ref enable");
      for (int k = 0; k < 8; k++) begin
        pllEnPin <= k[2];
        synthOverrideEnable <= k[1];
        synth_enable_override_value <= k[0];
        repeat (6) @(posedge sys_clk);
        s = k[1] ? k[0] : k[2];
        check(32'(synthEn), 32'(s), "synth enable");
        check(32'(refoDrive), 32'(s & e[0]), "ref drive");
      end
    end
    synthOverrideEnable <= 1'b0;
  endtask

  task automatic t_refused();
    wr(15'h0040, 8'h5a);
    rdreg(15'h0040, 8'h00, "unmapped read");
    rdreg(`TPSC_ADDR_PREEMPH, 8'h05, "unmapped write");
    u_host.cutAt = 4; // frame cut short
    wr(`TPSC_ADDR_PREEMPH, 8'h03);
    u_host.cutAt = -1;
    check(lanes, {8{4'h5}}, "aborted write");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    pllEnPin = 1'b1;
    synthOverrideEnable = 1'b0;
    synth_enable_override_value = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_timestamp();
    t_dividers();
    t_preemph();
    t_refout();
    t_refused();
    conclude();
  end
endmodule
`default_nettype wire
